// ### logic/pdm_pkg.sv
// constants and carriers for the program/data memory map block
// assumes a single 20 MHz core clock and an Avalon-MM master on the bus
package pdm_pkg;
  // clocking
  localparam int CLK_HZ = 20_000_000;
  localparam int CLKS_PER_ICYC = 4;
  localparam int TAB_ICYC = 2;
  localparam logic [1:0] PH_LAST = 2'(CLKS_PER_ICYC - 1);
  localparam logic [3:0] TAB_LOAD = 4'(TAB_ICYC * CLKS_PER_ICYC - 1);
  // bus layout
  localparam int AV_AW = 17;
  localparam int PROG_BIT = 16;
  localparam int BITOP_BIT = 8;
  localparam int BITOP_SET = 3;
  // program memory
  localparam int PROG_WORDS = 32768;
  localparam logic [14:0] PMASK_LARGE = 15'h7fff;
  localparam logic [14:0] PMASK_SMALL = 15'h3fff;
  localparam logic [6:0] LAST_PAGE = 7'h7f;
  // data memory
  localparam int GP_WORDS = 1024;
  localparam int GP_BIT = 7;
  localparam logic [2:0] DBMASK_LARGE = 3'h7;
  localparam logic [2:0] DBMASK_SMALL = 3'h3;
  localparam logic [7:0] BPMASK_LARGE = 8'h67;
  localparam logic [7:0] BPMASK_SMALL = 8'h27;
  localparam int BP_PBANK_LO = 5;
  // special function register addresses
  localparam logic [7:0] A_INDIRECT_PORT_FIRST = 8'h00;
  localparam logic [7:0] A_MP0 = 8'h01;
  localparam logic [7:0] A_INDIRECT_PORT_SECOND = 8'h02;
  localparam logic [7:0] A_MP1 = 8'h03;
  localparam logic [7:0] A_BP = 8'h04;
  localparam logic [7:0] A_PCL = 8'h06;
  localparam logic [7:0] A_TBLPTR = 8'h07;
  localparam logic [7:0] A_TABHI = 8'h08;
  localparam logic [7:0] A_INTEN = 8'h0b;
  localparam logic [7:0] A_CTRL2ND = 8'h1b;
  localparam logic [7:0] A_INTFLG = 8'h1e;
  localparam logic [7:0] A_TABCMD = 8'h2e;
  localparam logic [7:0] A_TABDST = 8'h2f;
  localparam logic [7:0] A_SPARE = 8'h7f;
  // interrupts
  localparam int NINT = 5;
  localparam int IB_EXT = 0;
  localparam int IB_MULTI = 4;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [12:0] VEC_RESET = 13'h0000;
  localparam logic [12:0] VEC_EXT = 13'h0004;
  localparam logic [12:0] VEC_TMR0 = 13'h0008;
  localparam logic [12:0] VEC_TMR1 = 13'h000c;
  localparam logic [12:0] VEC_TMR2 = 13'h0010;
  localparam logic [12:0] VEC_MULTI = 13'h0014;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TAB = 2'b01,
    ST_DONE = 2'b10
  } pdm_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [AV_AW-1:0] address;
    logic [15:0] writedata;
  } pdm_avreq_t;

  typedef struct packed {
    logic waitrequest;
    logic [15:0] readdata;
  } pdm_avrsp_t;

  typedef struct packed {
    logic voidAcc;
    logic viaSecond;
    logic [2:0] bank;
    logic [7:0] addr;
  } pdm_ea_t;
endpackage : pdm_pkg

// ### logic/pdm_memory_map.sv
// program and data memory map with table reads and interrupt vectoring
// assumes an Avalon-MM master and a core that reports stack state
//
// How it works
// RULE1: program memory is 16 bits wide, 16K or 32K words
// RULE2: small variant has two program banks chosen by bank register bit 5
// RULE3: large variant has four program banks chosen by bits 5 and 6
// RULE4: after reset the program counter holds the reset vector
// RULE5: enabled external edge vectors when the stack is not full
// RULE6: second control register picks falling, rising or both edges
// RULE7: each timer overflow vectors to its own entry when enabled
// RULE8: time base and both serial completions share one vector
// RULE9: table pointer gives the low eight table address bits
// RULE10: current page uses upper program counter bits, last page all ones
// RULE11: table address is 14 bits small, 15 bits large
// RULE12: low table byte goes to the named data location
// RULE13: high table byte goes to the table high byte register
// RULE14: table high byte register ignores writes
// RULE15: a table read takes two instruction cycles
// RULE16: data memory is 512 bytes in 4 banks or 1024 in 8
// RULE17: data memory starts at zero, special registers then general area
// RULE18: direct addressing reaches only bank 0
// RULE19: general locations read, write and support single bit set or clear
// RULE20: protected special registers ignore writes
// RULE21: unused special locations read as zero
// RULE22: indirect ports act on the location held in their pointer
// RULE23: only the second pointer pair reaches banks 1 to 7
// RULE24: with a full stack flags still set but vectoring waits
`timescale 1ns/10ps
module pdm_memory_map #(
  parameter bit largeVariant = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire pdm_pkg::pdm_avreq_t avReq,
  output pdm_pkg::pdm_avrsp_t avRsp,
  // interrupt sources
  input wire logic extIntPin,
  input wire logic [2:0] timerOvf,
  input wire logic timeBaseOvf,
  input wire logic [1:0] serialDone,
  // stack state from the core
  input wire logic stackFull,
  input wire logic interruptReturn,
  // fetch side
  output logic [14:0] fetchAddr,
  output logic [15:0] instrWord,
  output logic vectorTaken,
  output logic [14:0] vectorAddr
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam logic [14:0] PMASK = largeVariant ? pdm_pkg::PMASK_LARGE : pdm_pkg::PMASK_SMALL;
  localparam logic [2:0] DBMASK = largeVariant ? pdm_pkg::DBMASK_LARGE : pdm_pkg::DBMASK_SMALL;
  localparam logic [7:0] BPMASK = largeVariant ? pdm_pkg::BPMASK_LARGE : pdm_pkg::BPMASK_SMALL;

  logic [15:0] progMem [pdm_pkg::PROG_WORDS];
  logic [7:0] gpMem [pdm_pkg::GP_WORDS];

  pdm_pkg::pdm_state_t st_q, st_d;
  logic [15:0] rd_q, rd_d;
  logic [7:0] mp0_q, mp0_d, mp1_q, mp1_d, bp_q, bp_d;
  logic [7:0] tblPtr_q, tblPtr_d, tabHi_q, tabHi_d, tabDst_q, tabDst_d;
  logic [pdm_pkg::NINT-1:0] intEn_q, intEn_d;
  logic [1:0] edgeSel_q, edgeSel_d;
  logic [3:0] tabCnt_q, tabCnt_d;
  logic [14:0] tabAddr_q, tabAddr_d;
  logic tabLast_q, tabLast_d;

  logic [pdm_pkg::NINT-1:0] flag_q, flag_d, flagClr, events, takeMask;
  logic [12:0] pc_q, pc_d;
  logic [1:0] phase_q, phase_d;
  logic [14:0] fetchAddr_q, fetchAddr_d, vecAddr_q, vecAddr_d;
  logic [15:0] instr_q, instr_d;
  logic vecTaken_q, vecTaken_d;
  logic ext1_q, ext2_q, ext3_q, extEdge, take, icycTick, firstCyc_q;
  logic [12:0] vecOff;

  pdm_pkg::pdm_ea_t ea, wrEa;
  logic wrEn, progWe, pclWr, gpWe;
  logic [7:0] cur, wrVal, bitMask;
  logic [9:0] gpIdx;
  logic [14:0] pAddr;
  logic [15:0] progWord;
  logic [1:0] pBank;

  ////////////////////////////////////////////////////////////////////////////
  // address resolution for direct and indirect access
  function automatic pdm_pkg::pdm_ea_t resolve(input logic [7:0] a, input logic [7:0] p0,
                                               input logic [7:0] p1, input logic [2:0] db);
    pdm_pkg::pdm_ea_t e;
    e = '0;
    e.addr = a;
    if (a == pdm_pkg::A_INDIRECT_PORT_FIRST) begin
      e.addr = p0; // see RULE22
    end else if (a == pdm_pkg::A_INDIRECT_PORT_SECOND) begin
      e.addr = p1; // see RULE22
      e.bank = db; // see RULE23
      e.viaSecond = 1'b1;
    end
    e.voidAcc = (a == pdm_pkg::A_INDIRECT_PORT_FIRST || a == pdm_pkg::A_INDIRECT_PORT_SECOND) &&
                (e.addr == pdm_pkg::A_INDIRECT_PORT_FIRST || e.addr == pdm_pkg::A_INDIRECT_PORT_SECOND);
    return e;
  endfunction : resolve

  ////////////////////////////////////////////////////////////////////////////
  // register bus and table read
  assign pAddr = avReq.address[14:0] & PMASK; // see RULE1
  assign progWord = progMem[tabAddr_q];
  assign gpIdx = {wrEa.bank, wrEa.addr[6:0]}; // see RULE16
  assign gpWe = wrEn && !wrEa.voidAcc && wrEa.addr[pdm_pkg::GP_BIT]; // see RULE17
  assign avRsp = {st_q != pdm_pkg::ST_DONE, rd_q};

  always_comb begin
    st_d = st_q;
    rd_d = rd_q;
    mp0_d = mp0_q;
    mp1_d = mp1_q;
    bp_d = bp_q;
    tblPtr_d = tblPtr_q;
    tabHi_d = tabHi_q;
    tabDst_d = tabDst_q;
    intEn_d = intEn_q;
    edgeSel_d = edgeSel_q;
    tabCnt_d = tabCnt_q;
    tabAddr_d = tabAddr_q;
    tabLast_d = tabLast_q;
    wrEn = 1'b0;
    wrEa = '0;
    wrVal = 8'h00;
    progWe = 1'b0;
    pclWr = 1'b0;
    flagClr = '0;
    ea = resolve(avReq.address[7:0], mp0_q, mp1_q, bp_q[2:0] & DBMASK); // see RULE18
    bitMask = 8'h01 << avReq.writedata[2:0];
    cur = 8'h00;
    if (ea.voidAcc) begin
      cur = 8'h00;
    end else if (ea.addr[pdm_pkg::GP_BIT]) begin
      cur = gpMem[{ea.bank, ea.addr[6:0]}];
    end else if (ea.addr == pdm_pkg::A_MP0) begin
      cur = mp0_q;
    end else if (ea.addr == pdm_pkg::A_MP1) begin
      cur = mp1_q;
    end else if (ea.addr == pdm_pkg::A_BP) begin
      cur = bp_q;
    end else if (ea.addr == pdm_pkg::A_PCL) begin
      cur = pc_q[7:0];
    end else if (ea.addr == pdm_pkg::A_TBLPTR) begin
      cur = tblPtr_q;
    end else if (ea.addr == pdm_pkg::A_TABHI) begin
      cur = tabHi_q;
    end else if (ea.addr == pdm_pkg::A_INTEN) begin
      cur = {3'h0, intEn_q};
    end else if (ea.addr == pdm_pkg::A_CTRL2ND) begin
      cur = {6'h00, edgeSel_q};
    end else if (ea.addr == pdm_pkg::A_INTFLG) begin
      cur = {3'h0, flag_q};
    end else if (ea.addr == pdm_pkg::A_TABDST) begin
      cur = tabDst_q;
    end else begin
      cur = 8'h00; // see RULE21
    end
    case (st_q)
      pdm_pkg::ST_IDLE: begin
        if (avReq.read || avReq.write) begin
          st_d = pdm_pkg::ST_DONE;
          if (avReq.address[pdm_pkg::PROG_BIT]) begin
            if (avReq.write) begin
              progWe = 1'b1;
            end else begin
              rd_d = progMem[pAddr];
            end
          end else if (avReq.write) begin
            wrEn = 1'b1;
            wrEa = ea;
            if (!avReq.address[pdm_pkg::BITOP_BIT]) begin
              wrVal = avReq.writedata[7:0];
            end else if (avReq.writedata[pdm_pkg::BITOP_SET]) begin
              wrVal = cur | bitMask; // see RULE19
            end else begin
              wrVal = cur & ~bitMask; // see RULE19
            end
          end else begin
            rd_d = {8'h00, cur};
          end
        end
      end
      pdm_pkg::ST_TAB: begin
        if (tabCnt_q == '0) begin
          st_d = pdm_pkg::ST_DONE; // see RULE15
          wrEn = 1'b1;
          wrEa = resolve(tabDst_q, mp0_q, mp1_q, bp_q[2:0] & DBMASK);
          wrVal = progWord[7:0]; // see RULE12
          tabHi_d = progWord[15:8]; // see RULE13
        end else begin
          tabCnt_d = tabCnt_q - 4'h1;
        end
      end
      pdm_pkg::ST_DONE: begin
        st_d = pdm_pkg::ST_IDLE;
      end
      default: begin
        st_d = pdm_pkg::ST_IDLE;
      end
    endcase
    if (wrEn && !wrEa.voidAcc && !wrEa.addr[pdm_pkg::GP_BIT]) begin
      if (wrEa.addr == pdm_pkg::A_MP0) begin
        mp0_d = wrVal;
      end else if (wrEa.addr == pdm_pkg::A_MP1) begin
        mp1_d = wrVal;
      end else if (wrEa.addr == pdm_pkg::A_BP) begin
        bp_d = wrVal & BPMASK; // see RULE2, RULE3
      end else if (wrEa.addr == pdm_pkg::A_PCL) begin
        pclWr = 1'b1;
      end else if (wrEa.addr == pdm_pkg::A_TBLPTR) begin
        tblPtr_d = wrVal;
      end else if (wrEa.addr == pdm_pkg::A_INTEN) begin
        intEn_d = wrVal[pdm_pkg::NINT-1:0];
      end else if (wrEa.addr == pdm_pkg::A_CTRL2ND) begin
        edgeSel_d = wrVal[1:0]; // see RULE6
      end else if (wrEa.addr == pdm_pkg::A_INTFLG) begin
        flagClr = ~wrVal[pdm_pkg::NINT-1:0];
      end else if (wrEa.addr == pdm_pkg::A_TABDST) begin
        tabDst_d = wrVal;
      end else if (wrEa.addr == pdm_pkg::A_TABCMD && st_q == pdm_pkg::ST_IDLE) begin
        st_d = pdm_pkg::ST_TAB;
        tabCnt_d = pdm_pkg::TAB_LOAD; // see RULE15
        tabLast_d = wrVal[0];
        if (wrVal[0]) begin
          tabAddr_d = {pdm_pkg::LAST_PAGE, tblPtr_q} & PMASK; // see RULE10, RULE11
        end else begin
          tabAddr_d = {fetchAddr_q[14:8], tblPtr_q} & PMASK; // see RULE9, RULE10
        end
      end
      // table high byte and other special locations stay put: see RULE14, RULE20
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= pdm_pkg::ST_IDLE;
      rd_q <= 16'h0000;
      mp0_q <= 8'h00;
      mp1_q <= 8'h00;
      bp_q <= 8'h00;
      tblPtr_q <= 8'h00;
      tabHi_q <= 8'h00;
      tabDst_q <= 8'h00;
      intEn_q <= '0;
      edgeSel_q <= 2'h0;
      tabCnt_q <= 4'h0;
      tabAddr_q <= 15'h0000;
      tabLast_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_q <= rd_d;
      mp0_q <= mp0_d;
      mp1_q <= mp1_d;
      bp_q <= bp_d;
      tblPtr_q <= tblPtr_d;
      tabHi_q <= tabHi_d;
      tabDst_q <= tabDst_d;
      intEn_q <= intEn_d;
      edgeSel_q <= edgeSel_d;
      tabCnt_q <= tabCnt_d;
      tabAddr_q <= tabAddr_d;
      tabLast_q <= tabLast_d;
    end
  end

  // memories carry no reset
  always_ff @(posedge clk) begin
    if (gpWe) begin
      gpMem[gpIdx] <= wrVal; // see RULE19
    end
    if (progWe) begin
      progMem[pAddr] <= avReq.writedata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle, program counter and vectoring
  assign pBank = largeVariant ? bp_q[pdm_pkg::BP_PBANK_LO+1:pdm_pkg::BP_PBANK_LO]
                              : {1'b0, bp_q[pdm_pkg::BP_PBANK_LO]}; // see RULE2, RULE3
  assign icycTick = (phase_q == pdm_pkg::PH_LAST);
  assign fetchAddr = fetchAddr_q;
  assign instrWord = instr_q;
  assign vectorTaken = vecTaken_q;
  assign vectorAddr = vecAddr_q;

  always_comb begin
    case (edgeSel_q)
      pdm_pkg::EDGE_FALL: extEdge = ext3_q && !ext2_q;
      pdm_pkg::EDGE_RISE: extEdge = !ext3_q && ext2_q;
      pdm_pkg::EDGE_BOTH: extEdge = ext3_q != ext2_q;
      default: extEdge = 1'b0;
    endcase // see RULE6
    events = {timeBaseOvf || (|serialDone), timerOvf, extEdge}; // see RULE7, RULE8
    take = icycTick && (|(flag_q & intEn_q)) && (!stackFull || interruptReturn); // see RULE24
    takeMask = '0;
    vecOff = pdm_pkg::VEC_RESET;
    if (take) begin
      if (flag_q[0] && intEn_q[0]) begin
        takeMask = 5'h01;
        vecOff = pdm_pkg::VEC_EXT; // see RULE5
      end else if (flag_q[1] && intEn_q[1]) begin
        takeMask = 5'h02;
        vecOff = pdm_pkg::VEC_TMR0; // see RULE7
      end else if (flag_q[2] && intEn_q[2]) begin
        takeMask = 5'h04;
        vecOff = pdm_pkg::VEC_TMR1;
      end else if (flag_q[3] && intEn_q[3]) begin
        takeMask = 5'h08;
        vecOff = pdm_pkg::VEC_TMR2;
      end else begin
        takeMask = 5'h10;
        vecOff = pdm_pkg::VEC_MULTI; // see RULE8
      end
    end
    flag_d = (flag_q & ~flagClr & ~takeMask) | events; // see RULE24
    phase_d = phase_q + 2'h1;
    pc_d = pc_q;
    instr_d = instr_q;
    if (icycTick) begin
      pc_d = pc_q + 13'h0001;
      instr_d = progMem[fetchAddr_q]; // see RULE1
    end
    if (pclWr) begin
      pc_d = {pc_q[12:8], wrVal};
    end
    if (take) begin
      pc_d = vecOff; // see RULE5, RULE7
    end
    vecTaken_d = take;
    vecAddr_d = take ? {pBank, vecOff} : vecAddr_q;
    fetchAddr_d = {pBank, pc_d} & PMASK; // see RULE1
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      ext3_q <= 1'b0;
      flag_q <= '0;
      phase_q <= 2'h0;
      pc_q <= pdm_pkg::VEC_RESET; // see RULE4
      fetchAddr_q <= {2'h0, pdm_pkg::VEC_RESET}; // see RULE4
      instr_q <= 16'h0000;
      vecTaken_q <= 1'b0;
      vecAddr_q <= 15'h0000;
      firstCyc_q <= 1'b1;
    end else begin
      ext1_q <= extIntPin;
      ext2_q <= ext1_q;
      ext3_q <= ext2_q;
      flag_q <= flag_d;
      phase_q <= phase_d;
      pc_q <= pc_d;
      fetchAddr_q <= fetchAddr_d;
      instr_q <= instr_d;
      vecTaken_q <= vecTaken_d;
      vecAddr_q <= vecAddr_d;
      firstCyc_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  reset_vector_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE4
    firstCyc_q |-> fetchAddr_q == {2'h0, pdm_pkg::VEC_RESET})
    else $error("fetch does not start at the reset vector");
  vector_load_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE5
    take |=> vecTaken_q && fetchAddr_q[12:0] == vecAddr_q[12:0] && !vecTaken_d)
    else $error("taken interrupt did not load its vector");
  stack_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE24
    (stackFull && !interruptReturn) |=> !vecTaken_q)
    else $error("vectored while the stack was full");
  flag_set_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE7
    events[1] |=> flag_q[1])
    else $error("timer event did not set its flag");
  tab_two_cyc_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE15
    (st_q == pdm_pkg::ST_TAB && $past(st_q) != pdm_pkg::ST_TAB)
      |-> (st_q == pdm_pkg::ST_TAB)[*8] ##1 st_q == pdm_pkg::ST_DONE)
    else $error("table read length wrong");
  tab_last_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE10
    (st_q == pdm_pkg::ST_TAB && tabLast_q) |-> (&tabAddr_q[13:8]))
    else $error("last page address not all ones");
  tab_low_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE9
    st_q == pdm_pkg::ST_TAB |-> tabAddr_q[7:0] == tblPtr_q)
    else $error("table low address differs from pointer");
  tabhi_ro_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE14
    (wrEn && st_q == pdm_pkg::ST_IDLE && wrEa.addr == pdm_pkg::A_TABHI) |=> $stable(tabHi_q))
    else $error("table high byte was written");
  unused_zero_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE21
    (st_q == pdm_pkg::ST_IDLE && avReq.read && !avReq.address[pdm_pkg::PROG_BIT]
     && avReq.address[7:0] == pdm_pkg::A_SPARE) |=> rd_q == 16'h0000)
    else $error("unused location read nonzero");
  direct_bank_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE18
    (gpWe && gpIdx[9:7] != 3'h0) |-> wrEa.viaSecond)
    else $error("upper bank reached without the second pointer");
endmodule : pdm_memory_map

// ### tb/test_pdm_memory_map.sv
// self-checking bench for the program/data memory map block
// assumes the large variant, a 20 MHz clock and an Avalon-MM register bus
`timescale 1ns/10ps
module test_pdm_memory_map;
  logic clk;
  logic nrst;
  pdm_pkg::pdm_avreq_t avReq;
  pdm_pkg::pdm_avrsp_t avRsp;
  logic extIntPin;
  logic [5:0] evt;
  logic stackFull;
  logic interruptReturn;
  logic [14:0] fetchAddr;
  logic [15:0] instrWord;
  logic vectorTaken;
  logic [14:0] vectorAddr;
  logic [15:0] rdata;
  int err_total;
  int comparisons;
  int cycles;
  int lat;

  pdm_memory_map #(.largeVariant(1'b1)) pdm_memory_map_inst (
    .clk(clk), .nrst(nrst), .avReq(avReq), .avRsp(avRsp), .extIntPin(extIntPin),
    .timerOvf(evt[2:0]), .timeBaseOvf(evt[3]), .serialDone(evt[5:4]),
    .stackFull(stackFull), .interruptReturn(interruptReturn),
    .fetchAddr(fetchAddr), .instrWord(instrWord), .vectorTaken(vectorTaken),
    .vectorAddr(vectorAddr));

  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic fail(string msg);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_data(logic [15:0] got, logic [15:0] exp, string msg);
    comparisons++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask : chk_data

  task automatic chk_addr(logic [14:0] got, logic [14:0] exp, string msg);
    comparisons++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask : chk_addr

  task automatic chk_count(int got, int exp, string msg);
    comparisons++;
    if (got != exp) fail($sformatf("%s got %0d exp %0d", msg, got, exp));
  endtask : chk_count

  // one bus transfer; n returns cycles from the taking edge to the answer
  task automatic bus_xfer(logic rdNotWr, logic [16:0] addr, logic [15:0] data,
                          output logic [15:0] rdat, output int n);
    n = 0;
    @(posedge clk);
    avReq.read <= rdNotWr;
    avReq.write <= !rdNotWr;
    avReq.address <= addr;
    avReq.writedata <= data;
    do begin
      @(posedge clk);
      n++;
    end while (avRsp.waitrequest !== 1'b0);
    rdat = avRsp.readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    n = n - 1;
  endtask : bus_xfer

  task automatic wr(logic [16:0] addr, logic [15:0] data);
    bus_xfer(1'b0, addr, data, rdata, lat);
  endtask : wr

  task automatic rd_chk(logic [16:0] addr, logic [15:0] exp, string msg);
    bus_xfer(1'b1, addr, 16'h0000, rdata, lat);
    chk_data(rdata, exp, msg);
  endtask : rd_chk

  task automatic pulse(int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
  endtask : pulse

  task automatic wait_vec(logic [12:0] vec, string msg);
    bit found;
    found = 0;
    for (int i = 0; i < 40 && !found; i++) begin
      @(negedge clk);
      if (vectorTaken === 1'b1) begin
        found = 1;
        chk_addr(vectorAddr, 15'(vec), msg);
        chk_addr(fetchAddr, 15'(vec), {msg, " fetch"});
      end
    end
    if (!found) fail({msg, " vector not taken"});
  endtask : wait_vec

  task automatic no_vec(string msg);
    comparisons++;
    repeat (40) begin
      @(negedge clk);
      if (vectorTaken !== 1'b0) fail(msg);
    end
  endtask : no_vec

  // waits up to eight cycles for the fetched word to appear
  task automatic chk_instr(logic [15:0] exp, string msg);
    bit found;
    found = 0;
    for (int i = 0; i < 8 && !found; i++) begin
      @(negedge clk);
      found = (instrWord === exp);
    end
    chk_data(instrWord, exp, msg);
  endtask : chk_instr

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_data();
    wr(17'h00080, 16'h00c3);
    chk_count(lat, 1, "plain write latency");
    rd_chk(17'h00080, 16'h00c3, "ram readback");
    wr(17'h00180, 16'h0003);
    rd_chk(17'h00080, 16'h00c3, "bit3 clear no change");
    wr(17'h00180, 16'h000a);
    rd_chk(17'h00080, 16'h00c7, "bit2 set");
    wr(17'h00180, 16'h0007);
    rd_chk(17'h00080, 16'h0047, "bit7 clear");
    wr(17'h0007f, 16'h00aa);
    rd_chk(17'h0007f, 16'h0000, "unused reads zero");
    wr(17'h00004, 16'h00ff);
    rd_chk(17'h00004, 16'h0067, "bank select mask");
    wr(17'h00004, 16'h0002);
  endtask : t_data

  task automatic t_indirect();
    wr(17'h00090, 16'h0011);
    wr(17'h00003, 16'h0090);
    wr(17'h00002, 16'h005a);
    rd_chk(17'h00090, 16'h0011, "direct stays bank 0");
    rd_chk(17'h00002, 16'h005a, "second port bank 2");
    wr(17'h00001, 16'h0090);
    rd_chk(17'h00000, 16'h0011, "first port bank 0");
    wr(17'h00003, 16'h0002);
    rd_chk(17'h00002, 16'h0000, "port at port reads zero");
  endtask : t_indirect

  task automatic t_table();
    wr(17'h17f06, 16'h1a2b);
    wr(17'h17f05, 16'h0f0e);
    rd_chk(17'h17f06, 16'h1a2b, "program word");
    wr(17'h00007, 16'h0006);
    wr(17'h0002f, 16'h0081);
    wr(17'h0002e, 16'h0001);
    chk_count(lat, pdm_pkg::TAB_ICYC * pdm_pkg::CLKS_PER_ICYC + 1, "table time");
    rd_chk(17'h00081, 16'h002b, "table low byte");
    rd_chk(17'h00008, 16'h001a, "table high byte");
    wr(17'h00008, 16'h0055);
    rd_chk(17'h00008, 16'h001a, "high byte read only");
    wr(17'h00007, 16'h0005);
    wr(17'h0002e, 16'h0001);
    rd_chk(17'h00081, 16'h000e, "pointer low bits last page");
    rd_chk(17'h00008, 16'h000f, "high byte second read");
    wr(17'h00004, 16'h0022);
    wr(17'h12006, 16'h3c4d);
    wr(17'h00007, 16'h0006);
    wr(17'h0002e, 16'h0000);
    rd_chk(17'h00081, 16'h004d, "current page low byte");
    rd_chk(17'h00008, 16'h003c, "current page high byte");
    wr(17'h00004, 16'h0002);
  endtask : t_table

  task automatic t_ext();
    logic [1:0] modes [4];
    modes = '{2'h2, 2'h1, 2'h3, 2'h3};
    wr(17'h0000b, 16'h001f);
    foreach (modes[i]) begin
      wr(17'h0001b, {14'h0000, modes[i]});
      @(posedge clk);
      extIntPin <= ~extIntPin;
      wait_vec(pdm_pkg::VEC_EXT, "external edge");
    end
    wr(17'h0001b, 16'h0000);
    @(posedge clk);
    extIntPin <= ~extIntPin;
    no_vec("edge with no mode selected");
  endtask : t_ext

  task automatic t_timers();
    logic [12:0] tv [3];
    tv = '{pdm_pkg::VEC_TMR0, pdm_pkg::VEC_TMR1, pdm_pkg::VEC_TMR2};
    wr(17'h10008, 16'h5a5a);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      wait_vec(tv[i], "timer overflow");
      if (i == 0) chk_instr(16'h5a5a, "vector fetch word");
    end
    for (int i = 3; i < 6; i++) begin
      pulse(i);
      wait_vec(pdm_pkg::VEC_MULTI, "shared event");
    end
  endtask : t_timers

  task automatic t_stack();
    wr(17'h0001e, 16'h0000);
    @(posedge clk);
    stackFull <= 1'b1;
    pulse(1);
    no_vec("vector with full stack");
    rd_chk(17'h0001e, 16'h0004, "flag held");
    @(posedge clk);
    stackFull <= 1'b0;
    wait_vec(pdm_pkg::VEC_TMR1, "held vector");
    wr(17'h0000b, 16'h0000);
    pulse(0);
    no_vec("disabled timer");
  endtask : t_stack

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    avReq = '0;
    extIntPin = 1'b0;
    evt = 6'h00;
    stackFull = 1'b0;
    interruptReturn = 1'b0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk_addr(fetchAddr, 15'(pdm_pkg::VEC_RESET), "reset fetch");
    @(posedge clk);
    nrst <= 1'b1;
    t_data();
    t_indirect();
    t_table();
    t_ext();
    t_timers();
    t_stack();
    end_of_test();
  end
endmodule : test_pdm_memory_map
